// [adc_parallel_conversion_control.v]
// Digital control of a four channel successive approximation converter:
// parallel host port, start strobe handling, conversion timing from the
// master clock pin, output coding, channel sequencer and power state.
// Assumes the parallel host pins and the master clock pin are asynchronous to clk_i and that clk_i runs at least
// four times faster than the master clock pin; the analog core presents
// its raw code on raw_result_i when the conversion time ends.
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"

// How it works
// R1 - A falling edge of the start strobe while idle and powered begins a fresh conversion.
// R2 - That same falling edge switches the track/hold from track to hold.
// R3 - A rising start strobe edge wakes the part from auto shutdown or standby.
// R4 - A write strobe with device select low loads the bus into the control word.
// R5 - A read strobe with device select low puts the result on the data bus.
// R6 - Read and write strobes are ignored while device select is high.
// R7 - The channel comes from the address field or from the sequencer.
// R8 - The mode field sets single ended, differential or pseudo differential.
// R9 - The range bit picks a span of one or two times the reference.
// R10 - The coding bit picks straight binary or two's complement results.
// R11 - Busy rises after the start edge and falls once the result is stored.
// R12 - A conversion lasts thirteen and a half master clock periods.
// R13 - The control word is twelve bits, write only on the pins, reset to zero.
// R14 - Byte mode returns the low byte, or top bits with channel on lines 5-6.
// R15 - The host never asserts read and write together under device select.
module adc_parallel_conversion_control #(
    parameter RES_WIDTH = 12
) (
    input  wire                 clk_i,
    input  wire                 rst_i,
    // Wishbone slave.
    input  wire                 wb_cyc_i,
    input  wire                 wb_stb_i,
    input  wire                 wb_we_i,
    input  wire [3:0]           wb_adr_i,
    input  wire [3:0]           wb_sel_i,
    input  wire [31:0]          wb_dat_i,
    output reg  [31:0]          wb_dat_o,
    output reg                  wb_ack_o,
    // Parallel host pins.
    input  wire                 conversion_start_n_i,
    input  wire                 cs_n_i,
    input  wire                 rd_n_i,
    input  wire                 wr_n_i,
    input  wire                 word_mode_i,
    input  wire                 high_byte_select_i,
    input  wire [11:0]          db_i,
    output reg  [11:0]          db_o,
    output reg                  db_oe_o,
    output reg                  busy_o,
    // Master clock pin, sampled as a level.
    input  wire                 master_clock_in_i,
    // Analog core.
    input  wire [RES_WIDTH-1:0] raw_result_i,
    output reg                  hold_o,
    output reg  [1:0]           channel_o,
    output reg  [1:0]           input_mode_o,
    output reg                  range_double_o,
    output reg                  ref_internal_o,
    output reg                  powered_o
);

    // ============================================================
    // Input synchronisers.
    reg  [1:0]  cvs_sync_reg;
    reg  [1:0]  cs_sync_reg;
    reg  [1:0]  rd_sync_reg;
    reg  [1:0]  wr_sync_reg;
    reg  [1:0]  wm_sync_reg;
    reg  [1:0]  hb_sync_reg;
    reg  [1:0]  mck_sync_reg;
    reg  [11:0] db_meta_reg;
    reg  [11:0] db_sync_reg;

    // Delayed copies for edge detection.
    reg         cvs_last_reg;
    reg         wr_last_reg;
    reg         mck_last_reg;

    // Control and conversion state.
    reg  [11:0] ctrl_reg;
    reg  [11:0] ctrl_next;
    reg  [11:0] result_reg;
    reg  [1:0]  result_ch_reg;
    reg  [1:0]  seq_ch_reg;
    reg  [4:0]  half_cnt_reg;

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_CONV = 2'h1;
    reg  [1:0]  fsm_reg;

    wire        cvs_fall;
    wire        cvs_rise;
    wire        sel_active;
    wire        wr_done;
    wire        rd_active;
    wire        mck_edge;
    wire [1:0]  pm_mode;
    wire [1:0]  seq_mode;
    wire [1:0]  addr_ch;
    wire [1:0]  start_ch;
    wire [11:0] coded;
    wire        wb_req;
    wire        wb_wr;

    // The first stage of every synchroniser feeds only the second stage.
    always @(posedge clk_i) begin
        if (rst_i) begin
            cvs_sync_reg <= 2'h3;
            cs_sync_reg  <= 2'h3;
            rd_sync_reg  <= 2'h3;
            wr_sync_reg  <= 2'h3;
            wm_sync_reg  <= 2'h0;
            hb_sync_reg  <= 2'h0;
            mck_sync_reg <= 2'h0;
            db_meta_reg  <= 12'h000;
            db_sync_reg  <= 12'h000;
            cvs_last_reg <= 1'b1;
            wr_last_reg  <= 1'b1;
            mck_last_reg <= 1'b0;
        end else begin
            cvs_sync_reg <= {cvs_sync_reg[0], conversion_start_n_i};
            cs_sync_reg  <= {cs_sync_reg[0], cs_n_i};
            rd_sync_reg  <= {rd_sync_reg[0], rd_n_i};
            wr_sync_reg  <= {wr_sync_reg[0], wr_n_i};
            wm_sync_reg  <= {wm_sync_reg[0], word_mode_i};
            hb_sync_reg  <= {hb_sync_reg[0], high_byte_select_i};
            mck_sync_reg <= {mck_sync_reg[0], master_clock_in_i};
            db_meta_reg  <= db_i;
            db_sync_reg  <= db_meta_reg;
            cvs_last_reg <= cvs_sync_reg[1];
            wr_last_reg  <= wr_sync_reg[1];
            mck_last_reg <= mck_sync_reg[1];
        end
    end

    // ============================================================
    // Decoded pin events and control fields.
    assign cvs_fall   = cvs_last_reg & ~cvs_sync_reg[1];
    assign cvs_rise   = ~cvs_last_reg & cvs_sync_reg[1];
    assign sel_active = ~cs_sync_reg[1];                         // see R6
    // Data is taken as the write strobe rises, when the host holds it steady.
    // A read strobe held at the same time blocks the write.
    assign wr_done    = sel_active & ~wr_last_reg & wr_sync_reg[1]
                        & rd_sync_reg[1];                        // see R15
    assign rd_active  = sel_active & ~rd_sync_reg[1];            // see R5
    // Both master clock edges count, giving the half period in the count.
    assign mck_edge   = mck_last_reg ^ mck_sync_reg[1];          // see R12
    assign pm_mode    = {ctrl_reg[`CW_PM1], ctrl_reg[`CW_PM0]};
    assign seq_mode   = {ctrl_reg[`CW_SEQ1], ctrl_reg[`CW_SEQ0]};
    assign addr_ch    = {ctrl_reg[`CW_ADDR_HI], ctrl_reg[`CW_ADDR_LO]};
    assign start_ch   = (seq_mode == `SEQ_OFF) ? addr_ch
                        : seq_ch_reg;                            // see R7
    assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // A write lands at the edge where the master sees ack, not earlier.
    assign wb_wr      = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i
                        & (wb_adr_i == `REG_CONTROL);

    // Coding bit set gives straight binary; clear flips the MSB for two's
    // complement. Narrower results are left justified as on the pins.
    assign coded = {(raw_result_i[RES_WIDTH-1] ~^ ctrl_reg[`CW_CODING]),
                    raw_result_i[RES_WIDTH-2:0],
                    {(12-RES_WIDTH){1'b0}}};                     // see R10

    // ============================================================
    // Control word next value: pin writes first, Wishbone writes last.
    always @* begin
        ctrl_next = ctrl_reg;
        if (wr_done) begin                                       // see R4
            if (wm_sync_reg[1]) begin
                ctrl_next = db_sync_reg;
            end else if (hb_sync_reg[1]) begin                   // see R14
                ctrl_next[11:8] = db_sync_reg[3:0];
            end else begin
                ctrl_next[7:0] = db_sync_reg[7:0];
            end
        end
        if (wb_wr) begin
            if (wb_sel_i[0]) begin
                ctrl_next[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                ctrl_next[11:8] = wb_dat_i[11:8];
            end
        end
    end

    // ============================================================
    // Control register, reset to all zeros.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `CW_RESET;                               // see R13
        end else begin
            ctrl_reg <= ctrl_next;                               // see R4
        end
    end

    // ============================================================
    // Conversion sequence and power state. A start edge while powered
    // down is dropped: in the auto modes the host must first wake the part with a rising edge.
    always @(posedge clk_i) begin
        if (rst_i) begin
            fsm_reg       <= ST_IDLE;
            half_cnt_reg  <= 5'h00;
            hold_o        <= 1'b0;
            busy_o        <= 1'b0;
            powered_o     <= 1'b1;
            channel_o     <= 2'h0;
            seq_ch_reg    <= 2'h0;
            result_reg    <= 12'h000;
            result_ch_reg <= 2'h0;
        end else begin
            if (ctrl_next != ctrl_reg) begin
                seq_ch_reg <= 2'h0;
            end
            case (fsm_reg)
                ST_IDLE: begin
                    if (pm_mode == `PM_FULL_DOWN) begin
                        powered_o <= 1'b0;
                    end else if (pm_mode == `PM_NORMAL) begin
                        powered_o <= 1'b1;
                    end else if (cvs_rise) begin
                        powered_o <= 1'b1;                       // see R3
                    end
                    if (cvs_fall && powered_o) begin
                        fsm_reg      <= ST_CONV;                 // see R1
                        hold_o       <= 1'b1;                    // see R2
                        busy_o       <= 1'b1;                    // see R11
                        half_cnt_reg <= 5'h00;
                        channel_o    <= start_ch;                // see R7
                    end
                end
                ST_CONV: begin
                    if (mck_edge) begin
                        half_cnt_reg <= half_cnt_reg + 5'h01;
                    end
                    if (mck_edge &&
                        half_cnt_reg == `CONV_HALF_PERIODS - 5'h01) begin
                        // Result lands on the same edge that busy falls, so a read right
                        // after busy drops never sees the old code.
                        fsm_reg       <= ST_IDLE;                // see R12
                        hold_o        <= 1'b0;
                        busy_o        <= 1'b0;                   // see R11
                        result_reg    <= coded;
                        result_ch_reg <= channel_o;
                        if (seq_mode != `SEQ_OFF) begin
                            seq_ch_reg <= (channel_o >= addr_ch) ? 2'h0
                                          : channel_o + 2'h1;    // see R7
                        end
                        if (pm_mode == `PM_AUTO_DOWN ||
                            pm_mode == `PM_AUTO_STBY) begin
                            powered_o <= 1'b0;
                        end
                    end
                end
                default: begin
                    fsm_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Analog configuration straight from the control word.
    always @(posedge clk_i) begin
        if (rst_i) begin
            input_mode_o   <= 2'h0;
            range_double_o <= 1'b0;
            ref_internal_o <= 1'b0;
        end else begin
            input_mode_o   <= {ctrl_reg[`CW_MODE1],
                               ctrl_reg[`CW_MODE0]};             // see R8
            range_double_o <= ctrl_reg[`CW_RANGE];               // see R9
            ref_internal_o <= ctrl_reg[`CW_REF];
        end
    end

    // ============================================================
    // Parallel read port. Bus drive follows the strobes three clocks late,
    // the price of synchronising them.
    always @(posedge clk_i) begin
        if (rst_i) begin
            db_o    <= 12'h000;
            db_oe_o <= 1'b0;
        end else begin
            db_oe_o <= rd_active;                                // see R6
            if (wm_sync_reg[1]) begin
                db_o <= result_reg;                              // see R5
            end else if (hb_sync_reg[1]) begin
                db_o <= {5'h00, result_ch_reg, 1'b0,
                         result_reg[11:8]};                      // see R14
            end else begin
                db_o <= {4'h0, result_reg[7:0]};                 // see R14
            end
        end
    end

    // ============================================================
    // Wishbone slave: one wait state, ack for one cycle, unmapped reads zero.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                case (wb_adr_i)
                    `REG_CONTROL: wb_dat_o <= {20'h00000, ctrl_reg};
                    `REG_RESULT:  wb_dat_o <= {18'h00000, result_ch_reg,
                                               result_reg};
                    `REG_STATUS:  wb_dat_o <= {28'h0000000, powered_o,
                                               hold_o, busy_o,
                                               fsm_reg[0]};
                    default:      wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // adc_parallel_conversion_control

// [adc_ctrl_defines.vh]
// Constants shared by the converter control block: control word layout,
// power mode codes, conversion timing and the Wishbone register map.
// Assumes it is included by bare name from files that need it.
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// ============================================================
// Control word field positions.
`define CW_WIDTH        12
`define CW_RESET        12'h000
`define CW_PM1          11
`define CW_PM0          10
`define CW_CODING       9
`define CW_REF          8
`define CW_ZERO         7
`define CW_ADDR_HI      6
`define CW_ADDR_LO      5
`define CW_MODE1        4
`define CW_MODE0        3
`define CW_SEQ1         2
`define CW_SEQ0         1
`define CW_RANGE        0

// ============================================================
// Power mode codes held in the two power bits.
`define PM_NORMAL       2'h0
`define PM_FULL_DOWN    2'h1
`define PM_AUTO_DOWN    2'h2
`define PM_AUTO_STBY    2'h3

// ============================================================
// Sequencer codes held in the two sequence bits.
`define SEQ_OFF         2'h0

// ============================================================
// One conversion lasts 13.5 master clock periods, i.e. 27 half periods.
`define CONV_HALF_PERIODS 5'h1B

// ============================================================
// Wishbone register byte offsets.
`define REG_CONTROL     4'h0
`define REG_RESULT      4'h4
`define REG_STATUS      4'h8

`endif

// [adc_parallel_conversion_control_properties.sv]
// Concurrent checks on the ports of the converter control block.
// Assumes the bench toggles the master clock pin every 4 clk_i cycles.
`timescale 1ns/1ps

// ============================================================
// Port checker
module adc_ctrl_checker (
    input wire       clk_i,
    input wire       rst_i,
    input wire       wb_cyc_i,
    input wire       wb_stb_i,
    input wire       wb_ack_o,
    input wire       conversion_start_n_i,
    input wire       cs_n_i,
    input wire       rd_n_i,
    input wire       wr_n_i,
    input wire       busy_o,
    input wire       hold_o,
    input wire       db_oe_o,
    input wire       powered_o,
    input wire [1:0] input_mode_o,
    input wire       range_double_o,
    input wire       ref_internal_o
);
    // 27 edges of a 4-cycle half period, with slack for the synchronisers.
    localparam int LEN_LO = 100;
    localparam int LEN_HI = 116;
    logic [7:0] busy_cnt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Length of the busy pulse now running, cleared while idle.
    always @(posedge clk_i) begin
        if (rst_i || !busy_o) begin
            busy_cnt <= 8'h00;
        end else begin
            busy_cnt <= busy_cnt + 8'h01;
        end
    end

    AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
    AST_START: assert property (
        $fell(conversion_start_n_i) && !busy_o && powered_o
        |-> ##[1:4] busy_o) else $error("start edge did not set busy");
    AST_HOLD_ON: assert property ($rose(busy_o) |-> $rose(hold_o))
        else $error("hold not taken with busy");
    AST_HOLD_OFF: assert property ($fell(busy_o) |-> $fell(hold_o))
        else $error("hold not released with busy");
    AST_CONV_LEN: assert property ($fell(busy_o)
        |-> busy_cnt inside {[LEN_LO:LEN_HI]}) else $error("busy length");
    AST_CS_GATE: assert property (cs_n_i [*5] |-> !db_oe_o)
        else $error("bus driven without select");
    AST_READ_DRIVE: assert property ((!cs_n_i && !rd_n_i) [*5]
        |-> db_oe_o) else $error("read did not drive bus");
    AST_WRITE_ONLY: assert property ((wr_n_i && !wb_cyc_i) [*8]
        |-> $stable(input_mode_o) && $stable(range_double_o)
        && $stable(ref_internal_o)) else $error("config changed unwritten");
    AST_WAKE: assert property ($rose(powered_o)
        |-> conversion_start_n_i) else $error("wake without start high");
endmodule // adc_ctrl_checker

bind adc_parallel_conversion_control adc_ctrl_checker chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .conversion_start_n_i(conversion_start_n_i), .cs_n_i(cs_n_i),
    .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .busy_o(busy_o), .hold_o(hold_o),
    .db_oe_o(db_oe_o), .powered_o(powered_o),
    .input_mode_o(input_mode_o), .range_double_o(range_double_o),
    .ref_internal_o(ref_internal_o));

// [host_bus_model.sv]
// Host processor on the parallel pins: strobes, select and data.
// Assumes bus_i is the resolved level of the data pins.
`timescale 1ns/1ps

// ============================================================
// Host model
module host_bus_model (
    input  wire         clk_i,
    input  wire  [11:0] bus_i,
    output logic        start_n_o = 1'b1,
    output logic        cs_n_o    = 1'b1,
    output logic        rd_n_o    = 1'b1,
    output logic        wr_n_o    = 1'b1,
    output logic [11:0] bus_o     = 12'h000,
    output logic        bus_en_o  = 1'b0
);
    // Control write; read strobe stays high throughout.
    task automatic pin_write(input logic sel_n, input logic [11:0] d);
        @(posedge clk_i);
        cs_n_o   <= sel_n;
        bus_o    <= d;
        bus_en_o <= 1'b1;
        @(posedge clk_i);
        wr_n_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        wr_n_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        cs_n_o   <= 1'b1;
        bus_en_o <= 1'b0;
    endtask

    // Result read; the bus is released, so only the device drives it.
    task automatic pin_read(output logic [11:0] q);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        rd_n_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        q = bus_i;
        cs_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        repeat (5) @(posedge clk_i);
    endtask

    // Start pulse: the fall starts, the rise may wake.
    task automatic start_pulse();
        @(posedge clk_i);
        start_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        start_n_o <= 1'b1;
    endtask
endmodule // host_bus_model

// [adc_parallel_conversion_control_tb.sv]
// Self-checking bench for the converter control block.
// Assumes the host model owns the strobe, select and data pins; the bench drives the rest.
`timescale 1ns/1ps

// ============================================================
// Bench
module adc_parallel_conversion_control_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic        word_mode_i = 1'b1;
    logic        high_byte_select_i = 1'b0;
    logic        master_clock_in_i = 1'b0;
    logic [11:0] raw_result_i = 12'h000;
    logic [31:0] seed = 32'h0000005D;
    logic [31:0] cyc = 32'h0;
    logic [31:0] r;
    logic [31:0] d;
    logic [11:0] word;
    logic [11:0] q;
    logic [11:0] x;
    int          bad_count = 0;
    int          total_checks = 0;
    wire         st_n, cs_n, rd_n, wr_n, h_en, busy_o, hold_o, powered_o;
    wire         wb_ack_o, db_oe_o, range_double_o, ref_internal_o;
    wire [31:0]  wb_dat_o;
    wire [11:0]  h_bus, db_o;
    wire [1:0]   channel_o, input_mode_o;
    // Released pins show a pattern that moves every cycle, not a held value.
    wire [11:0]  db_w = h_en ? h_bus : (db_oe_o ? db_o : cyc[11:0]);

    adc_parallel_conversion_control dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .conversion_start_n_i(st_n), .cs_n_i(cs_n), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .word_mode_i(word_mode_i),
        .high_byte_select_i(high_byte_select_i), .db_i(db_w), .db_o(db_o),
        .db_oe_o(db_oe_o), .busy_o(busy_o),
        .master_clock_in_i(master_clock_in_i), .raw_result_i(raw_result_i),
        .hold_o(hold_o), .channel_o(channel_o), .input_mode_o(input_mode_o),
        .range_double_o(range_double_o), .ref_internal_o(ref_internal_o),
        .powered_o(powered_o));
    host_bus_model host_u (.clk_i(clk_i), .bus_i(db_w), .start_n_o(st_n),
        .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .bus_o(h_bus),
        .bus_en_o(h_en));

    // 100 MHz clock.
    initial forever #5 clk_i = ~clk_i;

    // Master clock of 8 cycles, and a hang limit well past the run length.
    always @(posedge clk_i) begin
        cyc <= cyc + 32'h1;
        master_clock_in_i <= cyc[2];
        if (cyc == 32'h00007530) begin
            bad_count++;
            summarize();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Coding bit set gives straight binary, clear flips the MSB.
    function automatic logic [11:0] code(input logic [11:0] v,
                                         input logic bin);
        return bin ? v : v ^ 12'h800;
    endfunction

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy_o !== lvl && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk("busy", {31'h0, lvl}, {31'h0, busy_o});
    endtask

    // Classic single cycle; the request is held until ack is sampled.
    task automatic wb_io(input logic we, input logic [3:0] a,
                         input logic [31:0] dd, output logic [31:0] rq);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= dd;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rq = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence: every mode with random fields, then bytes, then bus.
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("mode rst", 32'h0, {30'h0, input_mode_o});
        chk("pwr rst", 32'h1, {31'h0, powered_o});
        for (int i = 0; i < 4; i++) begin
            r = xs();
            word = {2'h0, r[0], r[1], 1'b0, r[3:2], i[1:0], 2'h0, r[4]};
            raw_result_i <= r[27:16];
            host_u.pin_write(1'b0, word);
            chk("mode", {30'h0, i[1:0]}, {30'h0, input_mode_o});
            chk("range", {31'h0, r[4]}, {31'h0, range_double_o});
            chk("ref", {31'h0, r[1]}, {31'h0, ref_internal_o});
            host_u.start_pulse();
            wait_busy(1'b1);
            chk("hold", 32'h1, {31'h0, hold_o});
            chk("chan", {30'h0, r[3:2]}, {30'h0, channel_o});
            wait_busy(1'b0);
            x = code(r[27:16], r[0]);
            host_u.pin_read(q);
            chk("word", {20'h0, x}, {20'h0, q});
        end
        $display("test modes done");
        word_mode_i <= 1'b0;
        host_u.pin_read(q);
        chk("lo byte", {24'h0, x[7:0]}, {20'h0, q});
        high_byte_select_i <= 1'b1;
        host_u.pin_read(q);
        chk("hi byte", {25'h0, r[3:2], 1'b0, x[11:8]}, {20'h0, q});
        host_u.pin_write(1'b0, 12'h001);
        chk("ref byte", 32'h1, {31'h0, ref_internal_o});
        word_mode_i <= 1'b1;
        high_byte_select_i <= 1'b0;
        host_u.pin_write(1'b1, ~word);
        chk("no sel", 32'h3, {30'h0, input_mode_o});
        chk("no sel", {31'h0, r[4]}, {31'h0, range_double_o});
        $display("test bytes done");
        r = xs();
        raw_result_i <= r[11:0];
        wb_io(1'b1, 4'h0, 32'h00000A20, d);
        host_u.start_pulse();
        wait_busy(1'b1);
        wb_io(1'b0, 4'h8, 32'h0, d);
        chk("status busy", 32'hF, d);
        wait_busy(1'b0);
        repeat (3) @(posedge clk_i);
        chk("pwr down", 32'h0, {31'h0, powered_o});
        host_u.start_pulse();
        repeat (8) @(posedge clk_i);
        chk("wake", 32'h1, {31'h0, powered_o});
        wb_io(1'b0, 4'h4, 32'h0, d);
        chk("result", {18'h0, 2'h1, r[11:0]}, d);
        wb_io(1'b0, 4'hC, 32'h0, d);
        chk("unmapped", 32'h0, d);
        wb_io(1'b0, 4'h8, 32'h0, d);
        chk("status", 32'h8, d);
        $display("test bus done");
        summarize();
    end
endmodule // adc_parallel_conversion_control_tb
